/* File: rtl/sfrt_pkg.sv */
// Shared constants of the sample FIFO and ready tracking block.
package sfrt_pkg;
   // *****************************************************************
   // Frame layout
   // *****************************************************************
   localparam int WORD_W = 32;
   localparam int NUM_CH = 4;
   localparam int FIFO_DEPTH = 2;
   localparam int BASE_WORDS = 1 + NUM_CH;
   localparam int MAX_WORDS = BASE_WORDS + 1;
   localparam int SAMPLE_W = NUM_CH * WORD_W;
   localparam int FRAME_W = MAX_WORDS * WORD_W;
   localparam int BITCNT_W = 8;
   // *****************************************************************
   // Status word fields
   // *****************************************************************
   localparam int STAT_RESYNC_BIT = 0;
   localparam int STAT_FULL_BIT = 1;
   localparam int STAT_EMPTY_BIT = 2;
   localparam logic [WORD_W-1:0] STAT_RESET = 32'h00000000;
   // *****************************************************************
   // Timing
   // *****************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int CONV_PERIOD_MCLK = 2048;
   localparam int MCLK_CNT_W = 16;
   localparam int READY_PULSE_NS = 40;
   localparam int READY_PULSE_CLKS =
      (READY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_CNT_W = 4;
endpackage : sfrt_pkg

/* File: rtl/sfrt_fifo2.sv */
// Small result FIFO with valid and ready on both sides and a flush.
`timescale 1ns/1ns
module sfrt_fifo2 #(
   parameter int WIDTH = 128,
   parameter int DEPTH = 2
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic flush,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready,
   output logic full
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
   localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_q;
   logic [PTR_W-1:0] rd_q;
   logic [CNT_W-1:0] cnt_q;
   logic push;
   logic pop;

   function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
      return (p == LAST) ? '0 : p + 1'b1;
   endfunction : ptr_next

   assign full = (cnt_q == DEPTH_C);
   assign in_ready = !full;
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready && !flush;
   assign pop = out_valid && out_ready && !flush;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || flush) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= ptr_next(wr_q);
         end
         if (pop) begin
            rd_q <= ptr_next(rd_q);
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule : sfrt_fifo2

/* File: rtl/sfrt_top.sv */
// Result FIFO, sample-ready pin, resync check and frame read-out.
`timescale 1ns/1ns
module sfrt_top
   import sfrt_pkg::*;
#(
   parameter int CONV_PERIOD = CONV_PERIOD_MCLK,
   parameter int FIFO_D = FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic master_clock_in,
   input wire logic sync_reset_n,
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   output logic spi_miso,
   output logic spi_miso_oe,
   input wire logic crc_enable,
   output logic conv_strobe,
   input wire logic sample_valid,
   input wire logic [SAMPLE_W-1:0] sample_data,
   output logic sample_ready,
   output logic sample_ready_n,
   output logic resync_fault_flag
);
   localparam logic [MCLK_CNT_W-1:0] PERIOD_LAST =
      MCLK_CNT_W'(CONV_PERIOD - 1);
   localparam logic [PULSE_CNT_W-1:0] PULSE_LEN =
      PULSE_CNT_W'(READY_PULSE_CLKS);

   // *****************************************************************
   // Pin synchronisers and edge detection
   // *****************************************************************
   logic [1:0] mclk_s_q;
   logic [1:0] sync_s_q;
   logic [1:0] cs_s_q;
   logic [1:0] sclk_s_q;
   logic mclk_d1_q;
   logic sync_d1_q;
   logic cs_d1_q;
   logic sclk_d1_q;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mclk_s_q <= 2'h0;
         sync_s_q <= 2'h3;
         cs_s_q <= 2'h3;
         sclk_s_q <= 2'h0;
         mclk_d1_q <= 1'b0;
         sync_d1_q <= 1'b1;
         cs_d1_q <= 1'b1;
         sclk_d1_q <= 1'b0;
      end else begin
         mclk_s_q <= {mclk_s_q[0], master_clock_in};
         sync_s_q <= {sync_s_q[0], sync_reset_n};
         cs_s_q <= {cs_s_q[0], spi_cs_n};
         sclk_s_q <= {sclk_s_q[0], spi_sclk};
         mclk_d1_q <= mclk_s_q[1];
         sync_d1_q <= sync_s_q[1];
         cs_d1_q <= cs_s_q[1];
         sclk_d1_q <= sclk_s_q[1];
      end
   end

   logic mclk_rise;
   logic sync_fall;
   logic cs_fall;
   logic cs_rise;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_active;

   assign mclk_rise = mclk_s_q[1] && !mclk_d1_q;
   assign sync_fall = !sync_s_q[1] && sync_d1_q;
   assign cs_fall = !cs_s_q[1] && cs_d1_q;
   assign cs_rise = cs_s_q[1] && !cs_d1_q;
   assign sclk_rise = sclk_s_q[1] && !sclk_d1_q;
   assign sclk_fall = !sclk_s_q[1] && sclk_d1_q;
   assign cs_active = !cs_s_q[1];

   // *****************************************************************
   // Conversion timing and sync check
   // *****************************************************************
   logic [MCLK_CNT_W-1:0] phase_q;
   logic misaligned;

   // A sync edge is legal only where a conversion period would begin.
   assign misaligned = sync_fall && (phase_q != '0);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         phase_q <= '0;
         conv_strobe <= 1'b0;
      end else begin
         conv_strobe <= 1'b0;
         // The sync edge only realigns the phase; conversions keep
         // coming from the master clock count alone.
         if (misaligned) begin
            phase_q <= '0;
         end else if (mclk_rise) begin
            if (phase_q == PERIOD_LAST) begin
               phase_q <= '0;
               conv_strobe <= 1'b1;
            end else begin
               phase_q <= phase_q + 1'b1;
            end
         end
      end
   end

   // *****************************************************************
   // Result FIFO and overflow
   // *****************************************************************
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [SAMPLE_W-1:0] fifo_out_data;
   logic fifo_full;
   logic fifo_pop;
   logic overflow;
   logic push;

   // A result arriving on a full FIFO empties it and is itself lost.
   assign overflow = sample_valid && !fifo_in_ready;
   assign push = sample_valid && fifo_in_ready;
   assign sample_ready = fifo_in_ready;

   sfrt_fifo2 #(
      .WIDTH(SAMPLE_W),
      .DEPTH(FIFO_D)
   ) u_fifo (
      .clk_sys(clk_sys),
      .srst(srst),
      .flush(overflow),
      .in_valid(sample_valid),
      .in_data(sample_data),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out_data),
      .out_ready(fifo_pop),
      .full(fifo_full)
   );

   // *****************************************************************
   // Sample-ready pulse
   // *****************************************************************
   logic [PULSE_CNT_W-1:0] pulse_q;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pulse_q <= '0;
         sample_ready_n <= 1'b1;
      end else if (push) begin
         pulse_q <= PULSE_LEN;
         sample_ready_n <= 1'b0;
      end else if (pulse_q > PULSE_CNT_W'(1)) begin
         pulse_q <= pulse_q - 1'b1;
      end else begin
         pulse_q <= '0;
         sample_ready_n <= 1'b1;
      end
   end

   // *****************************************************************
   // Frame read-out
   // *****************************************************************
   function automatic logic [BITCNT_W-1:0] frame_bits(input logic crc);
      return BITCNT_W'((crc ? MAX_WORDS : BASE_WORDS) * WORD_W);
   endfunction : frame_bits

   logic [FRAME_W-1:0] shift_q;
   logic [BITCNT_W-1:0] bits_q;
   logic held_q;
   logic flag_sent_q;
   logic frame_done;
   logic [WORD_W-1:0] status_word;

   always_comb begin
      status_word = STAT_RESET;
      status_word[STAT_RESYNC_BIT] = resync_fault_flag;
      status_word[STAT_FULL_BIT] = fifo_full;
      status_word[STAT_EMPTY_BIT] = !fifo_out_valid;
   end

   // Only a frame of at least the full length counts as a read.
   assign frame_done = cs_rise && (bits_q >= frame_bits(crc_enable));
   assign fifo_pop = frame_done && held_q;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         shift_q <= '0;
         bits_q <= '0;
         held_q <= 1'b0;
         flag_sent_q <= 1'b0;
         spi_miso <= 1'b0;
      end else begin
         if (overflow) begin
            held_q <= 1'b0;
         end
         if (cs_fall) begin
            // The CRC word is sent as zero; no checksum is built here.
            shift_q <= {status_word, fifo_out_data, {WORD_W{1'b0}}};
            bits_q <= '0;
            held_q <= fifo_out_valid && !overflow;
            flag_sent_q <= resync_fault_flag;
         end else if (cs_active) begin
            // Mode with data changed on the rising edge, sampled on falling.
            if (sclk_rise) begin
               spi_miso <= shift_q[FRAME_W-1];
               shift_q <= {shift_q[FRAME_W-2:0], 1'b0};
            end
            if (sclk_fall && (bits_q != '1)) begin
               bits_q <= bits_q + 1'b1;
            end
         end
         if (cs_rise) begin
            held_q <= 1'b0;
         end
      end
   end

   assign spi_miso_oe = cs_active;

   // *****************************************************************
   // Resync fault flag
   // *****************************************************************
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         resync_fault_flag <= 1'b0;
      end else if (misaligned) begin
         resync_fault_flag <= 1'b1;
      end else if (frame_done && flag_sent_q) begin
         resync_fault_flag <= 1'b0;
      end
   end
endmodule : sfrt_top

/* File: verif/sfrt_sva.sv */
// Port assertions of the sample FIFO and ready tracking block.
`timescale 1ns/1ns
module sfrt_chk (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic spi_cs_n,
   input wire logic spi_miso_oe,
   input wire logic conv_strobe,
   input wire logic sample_valid,
   input wire logic sample_ready,
   input wire logic sample_ready_n,
   input wire logic resync_fault_flag
);
   // **********
   // Properties
   // **********
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   sequence s_push; sample_valid && sample_ready; endsequence
   sequence s_low4; !sample_ready_n [*4]; endsequence
   property p_alert; s_push |=> s_low4; endproperty
   a_alert: assert property (p_alert)
      else $error("ready pulse missing");
   property p_cause; $fell(sample_ready_n) |-> $past(sample_valid);
   endproperty
   a_cause: assert property (p_cause)
      else $error("ready pulse without push");
   property p_ovf; sample_valid && !sample_ready |=> sample_ready;
   endproperty
   a_ovf: assert property (p_ovf)
      else $error("overflow did not flush");
   property p_fill; $fell(sample_ready) |-> $past(sample_valid); endproperty
   a_fill: assert property (p_fill)
      else $error("full without push");
   property p_oe_on; !spi_cs_n [*5] |-> spi_miso_oe; endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("output not driven in frame");
   property p_oe_off; spi_cs_n [*5] |-> !spi_miso_oe; endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("output driven outside frame");
   property p_clr; $fell(resync_fault_flag) |-> spi_cs_n; endproperty
   a_clr: assert property (p_clr)
      else $error("flag cleared inside frame");
   property p_strobe; conv_strobe |=> !conv_strobe; endproperty
   a_strobe: assert property (p_strobe)
      else $error("strobe longer than one cycle");
endmodule : sfrt_chk

/* File: verif/sfrt_host.sv */
// Host model: master clock, sync pin and SPI frame reads.
`timescale 1ns/1ns
module sfrt_host (
   input wire logic clk_sys,
   input wire logic spi_miso,
   output logic master_clock_in,
   output logic sync_reset_n,
   output logic spi_cs_n,
   output logic spi_sclk
);
   // ****
   // Host
   // ****
   initial begin
      master_clock_in = 1'b0;
      sync_reset_n = 1'b1;
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
   end
   // An odd half period keeps this clock out of step with the system clock.
   always #23 master_clock_in = ~master_clock_in;
   task read_frame(input int nbits, output logic [191:0] f);
      f = '0;
      @(negedge clk_sys);
      spi_cs_n = 1'b0;
      repeat (6) @(negedge clk_sys);
      for (int i = 0; i < nbits; i++) begin
         spi_sclk = 1'b1;
         repeat (6) @(negedge clk_sys);
         spi_sclk = 1'b0;
         f = {f[190:0], spi_miso};
         repeat (6) @(negedge clk_sys);
      end
      spi_cs_n = 1'b1;
      repeat (8) @(negedge clk_sys);
   endtask : read_frame
   task pulse_sync;
      sync_reset_n = 1'b0;
      repeat (8) @(negedge clk_sys);
      sync_reset_n = 1'b1;
   endtask : pulse_sync
endmodule : sfrt_host

/* File: verif/test_sample_fifo_ready_tracking.sv */
// Self-checking bench of the sample FIFO and ready tracking block.
`timescale 1ns/1ns
module test_sample_fifo_ready_tracking;
   import sfrt_pkg::*;
   logic clk_sys = 1'b0;
   logic srst, crc_enable, sample_valid, master_clock_in, sync_reset_n;
   logic spi_cs_n, spi_sclk, spi_miso, spi_miso_oe, conv_strobe;
   logic sample_ready, sample_ready_n, resync_fault_flag;
   logic [SAMPLE_W-1:0] sample_data;
   logic [191:0] fr;
   logic [127:0] st, dw;
   int miscompares = 0;
   int num_checks = 0;
   always #5 clk_sys = ~clk_sys;
   sfrt_top #(.CONV_PERIOD(8)) i_dut (.clk_sys, .srst, .master_clock_in,
      .sync_reset_n, .spi_cs_n, .spi_sclk, .spi_miso, .spi_miso_oe,
      .crc_enable, .conv_strobe, .sample_valid, .sample_data,
      .sample_ready, .sample_ready_n, .resync_fault_flag);
   sfrt_host i_host (.clk_sys, .spi_miso, .master_clock_in, .sync_reset_n,
      .spi_cs_n, .spi_sclk);
   // *******
   // Helpers
   // *******
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   task chk(input logic [127:0] seen, input logic [127:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wait_hi(ref logic s);
      int k;
      for (k = 0; k < 300 && s !== 1'b1; k++)
         @(negedge clk_sys);
      if (k == 300) begin
         miscompares++;
         finish_test;
      end
   endtask : wait_hi
   function automatic logic [127:0] pat(input logic [7:0] k);
      return {24'hA00000, k, 24'hB00000, k, 24'hC00000, k, 24'hD00000, k};
   endfunction : pat
   task push(input logic [7:0] k);
      @(negedge clk_sys);
      sample_valid = 1'b1;
      sample_data = pat(k);
      @(negedge clk_sys);
      sample_valid = 1'b0;
      sample_data = ~pat(k);
   endtask : push
   task rd(input int n);
      i_host.read_frame(n, fr);
      st = {96'h0, (n == 192) ? fr[191:160] : fr[159:128]};
      dw = (n == 192) ? fr[159:32] : fr[127:0];
   endtask : rd
   // *********
   // Scenarios
   // *********
   task t_basic_short;
      push(8'h01);
      chk({127'h0, sample_ready_n}, 128'h0);
      rd(160);
      chk(st, 128'h0);
      chk(dw, pat(8'h01));
      rd(160);
      chk(st, 128'h4);
      push(8'h02);
      rd(100);
      rd(160);
      chk(st, 128'h0);
      chk(dw, pat(8'h02));
      $display("done basic and short");
   endtask : t_basic_short
   task t_ovf;
      push(8'h03);
      push(8'h04);
      chk({127'h0, sample_ready}, 128'h0);
      push(8'h05);
      chk({127'h0, sample_ready}, 128'h1);
      // The pulse of the last good push has ended here; a dropped word
      // must not start a new one.
      repeat (2) @(negedge clk_sys);
      chk({127'h0, sample_ready_n}, 128'h1);
      rd(160);
      chk(st, 128'h4);
      push(8'h06);
      rd(160);
      chk(dw, pat(8'h06));
      $display("done overflow");
   endtask : t_ovf
   task t_crc;
      crc_enable = 1'b1;
      push(8'h07);
      rd(160);
      rd(192);
      chk(st, 128'h0);
      chk(dw, pat(8'h07));
      chk({96'h0, fr[31:0]}, 128'h0);
      rd(192);
      chk(st, 128'h4);
      crc_enable = 1'b0;
      $display("done crc frame");
   endtask : t_crc
   task t_sync;
      int n;
      repeat (2) begin
         wait_hi(conv_strobe);
         repeat (12) @(negedge clk_sys);
         i_host.pulse_sync;
         n = 0;
         repeat (22) begin
            @(negedge clk_sys);
            if (conv_strobe === 1'b1)
               n++;
         end
         chk(128'(n), 128'h0);
         chk({127'h0, resync_fault_flag}, 128'h1);
         rd(160);
         chk(st, 128'h5);
         rd(160);
         chk(st, 128'h4);
      end
      $display("done resync");
   endtask : t_sync
   initial begin
      srst = 1'b1;
      crc_enable = 1'b0;
      sample_valid = 1'b0;
      sample_data = '0;
      repeat (16) @(negedge clk_sys);
      srst = 1'b0;
      repeat (4) @(negedge clk_sys);
      t_basic_short;
      t_ovf;
      t_crc;
      t_sync;
      finish_test;
   end
endmodule : test_sample_fifo_ready_tracking
bind sfrt_top sfrt_chk i_chk (.clk_sys, .srst, .spi_cs_n, .spi_miso_oe,
   .conv_strobe, .sample_valid, .sample_ready, .sample_ready_n,
   .resync_fault_flag);
